// ---- logic/mmir_regs.vh ----
// Purpose: Register offsets, field positions, reset values and codes for the management
//          mode interrupt and restart unit.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave.
// Notes:   Definitions only.
`ifndef MMIR_REGS_VH
`define MMIR_REGS_VH

// ==========================================================
// Register offsets
`define MMIR_IO_RESTART_OFF 16'h7f00
`define MMIR_HALT_RESTART_OFF 16'h7f02
`define MMIR_CAP_ID_OFF 16'h7f04
`define MMIR_CTRL_OFF 16'h7f08
`define MMIR_STATUS_OFF 16'h7f0c
`define MMIR_TRAP_WORD_OFF 16'h7f10

// ==========================================================
// Capability identifier fields
`define MMIR_CAP_RELOC_BIT 17
`define MMIR_CAP_IOTRAP_BIT 16
`define MMIR_CAP_REV_DEFAULT 16'h0000

// ==========================================================
// Restart slot codes
`define MMIR_IO_RESTART_DO 16'h00ff
`define MMIR_IO_RESTART_NONE 16'h0000
`define MMIR_HALT_BIT 0

// ==========================================================
// Control register bits
`define MMIR_CTRL_IE_BIT 0
`define MMIR_CTRL_TF_BIT 1
`define MMIR_CTRL_DBG_BIT 2

// ==========================================================
// Status register bits
`define MMIR_ST_MODE_BIT 0
`define MMIR_ST_NMI_PEND_BIT 1
`define MMIR_ST_NMI_BLK_BIT 2
`define MMIR_ST_MGMT_PEND_BIT 3
`define MMIR_ST_B2B_BIT 4

`endif

// ---- logic/mmir_unit.v ----
// Purpose: Interrupt masking, request latching and restart slots around management mode.
// Assumes: One 20 MHz clock, synchronous active-high reset, software reaches the slots
//          over classic Wishbone; the core sequencer raises one-cycle instruction strobes.
// Notes:   Request pins from the chipset pass a three-stage synchroniser.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "mmir_regs.vh"

module mmir_unit #(
  parameter [15:0] REV_LEVEL = `MMIR_CAP_REV_DEFAULT,
  parameter RELOC_SUPPORTED = 1,
  parameter IOTRAP_SUPPORTED = 1
)(
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Request pins from outside.
  input wire mgmt_interrupt_request_n_i,
  input wire nmi_request_i,
  input wire maskable_int_request_i,
  // Core instruction events, one-cycle strobes at instruction boundaries.
  input wire boundary_i,
  input wire halted_i,
  input wire io_boundary_i,
  input wire [31:0] io_trap_word_i,
  input wire resume_from_mgmt_instr_i,
  input wire interrupt_return_instr_i,
  input wire set_ie_flag_instr_i,
  input wire soft_int_instr_i,
  input wire [7:0] soft_int_vector_i,
  input wire halt_cache_hit_i,
  // Outputs to the core.
  output reg system_mgmt_mode_o,
  output reg mgmt_ack_o,
  output reg nmi_take_o,
  output reg maskable_int_request_take_o,
  output reg soft_int_take_o,
  output reg [31:0] vector_addr_o,
  output reg clear_flags_o,
  output reg ie_flag_o,
  output reg tf_flag_o,
  output reg debug_en_o,
  output reg halt_reenter_o,
  output reg halt_fetch_o,
  output reg halt_cycle_o,
  output reg io_reexec_o,
  output reg resume_next_o,
  output reg [31:0] cap_save_o,
  output reg cap_save_we_o
);

  // ==========================================================
  // Capability identifier.
  function [31:0] cap_word;
    input dummy;
    begin
      cap_word = 32'h0000_0000;
      cap_word[`MMIR_CAP_RELOC_BIT] = (RELOC_SUPPORTED != 0);
      cap_word[`MMIR_CAP_IOTRAP_BIT] = (IOTRAP_SUPPORTED != 0);
      cap_word[15:0] = REV_LEVEL;
    end
  endfunction

  // Real mode vector address: four bytes per entry from address zero.
  function [31:0] rm_vector;
    input [7:0] vec;
    begin
      rm_vector = {22'h00_0000, vec, 2'b00};
    end
  endfunction

  // ==========================================================
  // Pin synchronisers.
  reg [2:0] smi_sync_reg;
  reg [2:0] nmi_sync_reg;
  reg [2:0] maskable_int_request_sync_reg;
  reg smi_level_reg;
  reg nmi_level_reg;
  reg maskable_int_request_level_reg;
  wire smi_rise;
  wire nmi_rise;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      smi_sync_reg <= 3'b111;
      nmi_sync_reg <= 3'b000;
      maskable_int_request_sync_reg <= 3'b000;
      smi_level_reg <= 1'b0;
      nmi_level_reg <= 1'b0;
      maskable_int_request_level_reg <= 1'b0;
    end
    else
    begin
      smi_sync_reg <= {smi_sync_reg[1:0], mgmt_interrupt_request_n_i};
      nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_request_i};
      maskable_int_request_sync_reg <= {maskable_int_request_sync_reg[1:0], maskable_int_request_i};
      if (smi_sync_reg[1] == smi_sync_reg[2])
        smi_level_reg <= ~smi_sync_reg[2];
      if (nmi_sync_reg[1] == nmi_sync_reg[2])
        nmi_level_reg <= nmi_sync_reg[2];
      if (maskable_int_request_sync_reg[1] == maskable_int_request_sync_reg[2])
        maskable_int_request_level_reg <= maskable_int_request_sync_reg[2];
    end
  end

  assign smi_rise = (smi_sync_reg[1] == smi_sync_reg[2]) && ~smi_sync_reg[2] && ~smi_level_reg;
  assign nmi_rise = (nmi_sync_reg[1] == nmi_sync_reg[2]) && nmi_sync_reg[2] && ~nmi_level_reg;

  // ==========================================================
  // Mode state.
  localparam [2:0] ST_NORMAL = 3'b001;
  localparam [2:0] ST_MGMT = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;

  reg [2:0] state_reg;
  reg smi_pend_reg;
  reg nmi_pend_reg;
  reg nmi_blk_reg;
  reg b2b_reg;
  reg smi_late_reg;
  reg [15:0] io_slot_reg;
  reg [15:0] halt_slot_reg;
  reg [31:0] cap_reg;
  reg [31:0] trap_word_reg;
  wire in_mode;
  wire enter;
  wire resume;
  wire wb_req;
  wire wb_wr;

  assign in_mode = state_reg[1];
  assign enter = boundary_i && (smi_rise || smi_pend_reg) && !in_mode;
  assign resume = resume_from_mgmt_instr_i && in_mode;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_NORMAL;
      smi_pend_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
      nmi_blk_reg <= 1'b0;
      b2b_reg <= 1'b0;
      smi_late_reg <= 1'b0;
      io_slot_reg <= `MMIR_IO_RESTART_NONE;
      halt_slot_reg <= 16'h0000;
      // The capability bits are fixed, so they read correctly even before any entry.
      cap_reg <= cap_word(1'b0);
      trap_word_reg <= 32'h0000_0000;
      system_mgmt_mode_o <= 1'b0;
      mgmt_ack_o <= 1'b0;
      nmi_take_o <= 1'b0;
      maskable_int_request_take_o <= 1'b0;
      soft_int_take_o <= 1'b0;
      vector_addr_o <= 32'h0000_0000;
      clear_flags_o <= 1'b0;
      ie_flag_o <= 1'b0;
      tf_flag_o <= 1'b0;
      debug_en_o <= 1'b0;
      halt_reenter_o <= 1'b0;
      halt_fetch_o <= 1'b0;
      halt_cycle_o <= 1'b0;
      io_reexec_o <= 1'b0;
      resume_next_o <= 1'b0;
      cap_save_o <= 32'h0000_0000;
      cap_save_we_o <= 1'b0;
    end
    else
    begin
      mgmt_ack_o <= 1'b0;
      nmi_take_o <= 1'b0;
      maskable_int_request_take_o <= 1'b0;
      soft_int_take_o <= 1'b0;
      clear_flags_o <= 1'b0;
      halt_reenter_o <= 1'b0;
      halt_fetch_o <= 1'b0;
      halt_cycle_o <= 1'b0;
      io_reexec_o <= 1'b0;
      resume_next_o <= 1'b0;
      cap_save_we_o <= 1'b0;
      if (wb_wr && wb_adr_i == `MMIR_IO_RESTART_OFF && wb_sel_i[0])
        io_slot_reg <= wb_dat_i[15:0];
      if (wb_wr && wb_adr_i == `MMIR_HALT_RESTART_OFF && wb_sel_i[0])
        halt_slot_reg <= wb_dat_i[15:0];
      if (wb_wr && wb_adr_i == `MMIR_CTRL_OFF && wb_sel_i[0])
      begin
        ie_flag_o <= wb_dat_i[`MMIR_CTRL_IE_BIT];
        tf_flag_o <= wb_dat_i[`MMIR_CTRL_TF_BIT];
        debug_en_o <= wb_dat_i[`MMIR_CTRL_DBG_BIT];
      end
      if (set_ie_flag_instr_i)
        ie_flag_o <= 1'b1;
      // A blocked request arriving now is kept once; later edges are dropped.
      if (nmi_rise && (nmi_blk_reg || in_mode))
        nmi_pend_reg <= 1'b1;
      // A request edge is kept until a boundary takes it; in mode only the first one counts.
      if (smi_rise)
        smi_pend_reg <= 1'b1;
      if (smi_rise && in_mode)
        smi_late_reg <= 1'b1;
      if (soft_int_instr_i)
      begin
        soft_int_take_o <= 1'b1;
        vector_addr_o <= rm_vector(soft_int_vector_i);
      end
      case (state_reg)
        ST_NORMAL, ST_HALT:
        begin
          if (enter)
          begin
            state_reg <= ST_MGMT;
            smi_pend_reg <= 1'b0;
            system_mgmt_mode_o <= 1'b1;
            mgmt_ack_o <= 1'b1;
            clear_flags_o <= 1'b1;
            ie_flag_o <= 1'b0;
            tf_flag_o <= 1'b0;
            debug_en_o <= 1'b0;
            nmi_blk_reg <= 1'b1;
            io_slot_reg <= `MMIR_IO_RESTART_NONE;
            halt_slot_reg <= {15'h0000, halted_i || state_reg[2]};
            cap_reg <= cap_word(1'b0);
            cap_save_o <= cap_word(1'b0);
            cap_save_we_o <= 1'b1;
            trap_word_reg <= (io_boundary_i && !smi_late_reg) ? io_trap_word_i :
                             32'h0000_0000;
            b2b_reg <= smi_late_reg;
            smi_late_reg <= 1'b0;
          end
          else if (nmi_rise || (nmi_pend_reg && !nmi_blk_reg))
          begin
            nmi_pend_reg <= 1'b0;
            nmi_take_o <= 1'b1;
            vector_addr_o <= rm_vector(8'h02);
            state_reg <= ST_NORMAL;
          end
        end
        ST_MGMT:
        begin
          if (resume)
          begin
            state_reg <= (halt_slot_reg[`MMIR_HALT_BIT] && !nmi_pend_reg) ? ST_HALT : ST_NORMAL;
            system_mgmt_mode_o <= 1'b0;
            nmi_blk_reg <= 1'b0;
            cap_reg <= cap_word(1'b0);
            if (nmi_pend_reg)
            begin
              nmi_pend_reg <= 1'b0;
              nmi_take_o <= 1'b1;
              vector_addr_o <= rm_vector(8'h02);
            end
            else if (halt_slot_reg[`MMIR_HALT_BIT])
            begin
              halt_reenter_o <= 1'b1;
              halt_fetch_o <= !halt_cache_hit_i;
              halt_cycle_o <= 1'b1;
            end
            else if (io_slot_reg == `MMIR_IO_RESTART_DO)
              io_reexec_o <= 1'b1;
            else
              resume_next_o <= 1'b1;
          end
          else
          begin
            if (interrupt_return_instr_i)
              nmi_blk_reg <= 1'b0;
            if ((nmi_rise || nmi_pend_reg) && !nmi_blk_reg && !interrupt_return_instr_i)
            begin
              nmi_pend_reg <= 1'b0;
              nmi_take_o <= 1'b1;
              vector_addr_o <= rm_vector(8'h02);
            end
            else if (maskable_int_request_level_reg && ie_flag_o && boundary_i)
              maskable_int_request_take_o <= 1'b1;
          end
        end
        default:
          state_reg <= ST_NORMAL;
      endcase
      if (state_reg[0] && maskable_int_request_level_reg && ie_flag_o && boundary_i && !enter)
        maskable_int_request_take_o <= 1'b1;
    end
  end

  // ==========================================================
  // Wishbone read path; one wait-free cycle answer, unmapped reads give zero.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      case (wb_adr_i)
        `MMIR_IO_RESTART_OFF: wb_dat_o <= {16'h0000, io_slot_reg};
        `MMIR_HALT_RESTART_OFF: wb_dat_o <= {16'h0000, halt_slot_reg};
        `MMIR_CAP_ID_OFF: wb_dat_o <= cap_reg;
        `MMIR_CTRL_OFF: wb_dat_o <= {29'h0000_0000, debug_en_o, tf_flag_o, ie_flag_o};
        `MMIR_STATUS_OFF: wb_dat_o <= {27'h0000_0000, b2b_reg, smi_pend_reg, nmi_blk_reg,
                                       nmi_pend_reg, in_mode};
        `MMIR_TRAP_WORD_OFF: wb_dat_o <= trap_word_reg;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ---- tb/mmir_unit_monitor.sv ----
// Purpose: Port checker for the management mode interrupt unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the unit from the bench top.
`timescale 1ns/1ns
module mmir_unit_monitor (
  // Clock, reset and bus.
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  // Core side.
  input wire system_mgmt_mode_o, mgmt_ack_o, clear_flags_o, ie_flag_o, tf_flag_o,
  input wire debug_en_o, cap_save_we_o, nmi_take_o, soft_int_take_o, maskable_int_request_take_o,
  input wire halt_reenter_o, halt_fetch_o, halt_cycle_o, io_reexec_o, resume_next_o,
  input wire [31:0] cap_save_o,
  input wire [31:0] vector_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Properties
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or too long");
  property p_entry;
    $rose(system_mgmt_mode_o) |-> !ie_flag_o && !tf_flag_o && !debug_en_o;
  endproperty
  a_entry: assert property (p_entry) else $error("flags not cleared on entry");
  property p_save;
    $rose(system_mgmt_mode_o) |-> mgmt_ack_o && cap_save_we_o && clear_flags_o;
  endproperty
  a_save: assert property (p_save) else $error("entry without save");
  property p_cap;
    cap_save_we_o |-> cap_save_o[31:16] == 16'h0003;
  endproperty
  a_cap: assert property (p_cap) else $error("capability bits wrong");
  property p_resume;
    $fell(system_mgmt_mode_o) |-> $onehot({nmi_take_o, halt_reenter_o, io_reexec_o,
      resume_next_o});
  endproperty
  a_resume: assert property (p_resume) else $error("resume action not unique");
  property p_halt;
    halt_fetch_o || halt_cycle_o |-> halt_reenter_o && halt_cycle_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt restart cycle wrong");
  property p_nmivec;
    nmi_take_o |-> vector_addr_o == 32'h0000_0008;
  endproperty
  a_nmivec: assert property (p_nmivec) else $error("nmi vector wrong");
  property p_soft;
    soft_int_take_o |-> vector_addr_o[31:10] == 0 && vector_addr_o[1:0] == 0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft vector outside table");
  property p_maskable_int_request;
    maskable_int_request_take_o |-> $past(ie_flag_o);
  endproperty
  a_maskable_int_request: assert property (p_maskable_int_request) else $error("maskable_int_request taken with flag clear");
  property p_nmiblk;
    $rose(system_mgmt_mode_o) |-> !nmi_take_o [*2];
  endproperty
  a_nmiblk: assert property (p_nmiblk) else $error("nmi taken at entry");
  property p_nmione;
    nmi_take_o |=> !nmi_take_o;
  endproperty
  a_nmione: assert property (p_nmione) else $error("nmi serviced twice");
  c_nmi: cover property ($fell(system_mgmt_mode_o) && nmi_take_o);
  c_halt: cover property (halt_reenter_o);
  c_io: cover property (io_reexec_o);
endmodule

// ---- tb/mmir_chipset_model.sv ----
// Purpose: Chipset side that drives the management request pin.
// Assumes: Pin is active low and idles high.
// Notes:   Holds the request eight cycles so the synchroniser sees it.
`timescale 1ns/1ns
module mmir_chipset_model (
  // Clock and trigger.
  input wire clk_i,
  input wire fire_i,
  // Request pin.
  output wire mgmt_interrupt_request_n_o
);
  logic [3:0] cnt_reg = 4'h0;
  always @(posedge clk_i)
  begin
    if (fire_i)
      cnt_reg <= 4'h8;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
  assign mgmt_interrupt_request_n_o = (cnt_reg == 4'h0);
endmodule

// ---- tb/mmir_unit_tb_top.sv ----
// Purpose: Self-checking bench for the management mode interrupt unit.
// Assumes: 20 MHz clock; the chipset model drives the request pin.
// Notes:   Cache hit input is tied low, so only the miss path is seen.
`timescale 1ns/1ns
`include "mmir_regs.vh"
module mmir_unit_tb_top;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0, fire = 0, nmi = 0, maskable_int_request = 0, hlt = 0, iob = 0, clr = 0;
  logic [3:0] sel = 0;
  logic [15:0] adr = 0;
  logic [31:0] wd = 0, q;
  logic [4:0] ev = 0;
  logic [7:0] seen;
  wire [31:0] rd, vec, cap;
  wire ack, req_n, mode, ie, nt, it, st, hr, hf, hc, io, rn;
  integer n_errors = 0, n_compared = 0;
  mmir_chipset_model i_mmir_chipset_model (.clk_i(clk_i), .fire_i(fire),
    .mgmt_interrupt_request_n_o(req_n));
  mmir_unit i_mmir_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .mgmt_interrupt_request_n_i(req_n), .nmi_request_i(nmi), .maskable_int_request_i(maskable_int_request),
    .boundary_i(ev[0]), .halted_i(hlt), .io_boundary_i(iob), .io_trap_word_i(32'h1234_0003),
    .resume_from_mgmt_instr_i(ev[1]), .interrupt_return_instr_i(ev[2]),
    .set_ie_flag_instr_i(ev[3]), .soft_int_instr_i(ev[4]), .soft_int_vector_i(8'h21),
    .halt_cache_hit_i(1'b0), .system_mgmt_mode_o(mode), .mgmt_ack_o(), .nmi_take_o(nt),
    .maskable_int_request_take_o(it), .soft_int_take_o(st), .vector_addr_o(vec), .clear_flags_o(),
    .ie_flag_o(ie), .tf_flag_o(), .debug_en_o(), .halt_reenter_o(hr), .halt_fetch_o(hf),
    .halt_cycle_o(hc), .io_reexec_o(io), .resume_next_o(rn), .cap_save_o(cap),
    .cap_save_we_o());
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) seen <= clr ? 8'h00 : seen | {it, st, nt, hr, hf, hc, io, rn};
  // ==========================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Holds the request until ack is sampled, then releases it.
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    integer i;
    @(posedge clk_i);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hf};
    for (i = 0; i < 16 && ack !== 1'b1; i++) @(posedge clk_i);
    q = rd;
    {cyc, stb} <= 2'b00;
    if (i >= 16)
    begin
      n_errors++;
      stop_test;
    end
  endtask
  task rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(nm, q, e);
  endtask
  task pulse(input logic [4:0] w);
    @(posedge clk_i);
    ev <= w;
    @(posedge clk_i);
    ev <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  task clear;
    @(posedge clk_i);
    clr <= 1;
    @(posedge clk_i);
    clr <= 0;
  endtask
  task kick;
    @(posedge clk_i);
    fire <= 1;
    @(posedge clk_i);
    fire <= 0;
    repeat (6) @(posedge clk_i);
  endtask
  task nmi_rise;
    @(posedge clk_i);
    nmi <= 1;
    repeat (6) @(posedge clk_i);
    nmi <= 0;
    repeat (2) @(posedge clk_i);
  endtask
  task enter(input logic h, input logic i);
    {hlt, iob} <= {h, i};
    kick;
    pulse(5'h01);
    chk("mode", mode, 1);
  endtask
  task resume(input logic [7:0] e);
    clear;
    pulse(5'h02);
    chk("resume", seen, e);
    chk("exit", mode, 0);
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    chk("reset mode", mode, 0);
    rdc("cap id", `MMIR_CAP_ID_OFF, 32'h0003_0000);
    wb(1, 16'h7f40, 32'hffff_ffff);
    rdc("unmapped", 16'h7f40, 32'h0000_0000);
  endtask
  task t_first;
    enter(1, 1);
    rdc("ctrl", `MMIR_CTRL_OFF, 32'h0000_0000);
    rdc("halt slot", `MMIR_HALT_RESTART_OFF, 32'h0000_0001);
    rdc("io slot", `MMIR_IO_RESTART_OFF, 32'h0000_0000);
    rdc("trap", `MMIR_TRAP_WORD_OFF, 32'h1234_0003);
    chk("cap save", cap, 32'h0003_0000);
    clear;
    pulse(5'h10);
    chk("soft", seen[6], 1);
    chk("soft vec", vec, 32'h0000_0084);
    nmi_rise;
    nmi_rise;
    kick;
    chk("nmi held", seen[5], 0);
    rdc("status", `MMIR_STATUS_OFF, 32'h0000_000f);
    wb(1, `MMIR_IO_RESTART_OFF, 32'h0000_00ff);
    wb(1, `MMIR_HALT_RESTART_OFF, 32'h0000_0000);
    resume(8'h20);
    chk("nmi vec", vec, 32'h0000_0008);
    rdc("status out", `MMIR_STATUS_OFF, 32'h0000_0008);
  endtask
  task t_b2b;
    {hlt, iob} <= 2'b00;
    pulse(5'h01);
    chk("b2b mode", mode, 1);
    rdc("b2b trap", `MMIR_TRAP_WORD_OFF, 32'h0000_0000);
    rdc("b2b halt", `MMIR_HALT_RESTART_OFF, 32'h0000_0000);
    // Every entry, the second of a back-to-back pair too, clears the I/O slot to none.
    rdc("b2b io slot", `MMIR_IO_RESTART_OFF, 32'h0000_0000);
    resume(8'h01);
  endtask
  task t_halt;
    enter(1, 0);
    resume(8'h1c);
  endtask
  task t_flags;
    enter(1, 1);
    maskable_int_request <= 1;
    repeat (5) @(posedge clk_i);
    clear;
    pulse(5'h01);
    chk("maskable_int_request masked", seen[7], 0);
    pulse(5'h08);
    chk("ie", ie, 1);
    pulse(5'h01);
    chk("maskable_int_request taken", seen[7], 1);
    maskable_int_request <= 0;
    nmi_rise;
    clear;
    pulse(5'h04);
    pulse(5'h01);
    chk("nmi after interrupt_return_instr", seen[5], 1);
    wb(1, `MMIR_HALT_RESTART_OFF, 32'h0000_0000);
    wb(1, `MMIR_IO_RESTART_OFF, 32'h0000_00ff);
    resume(8'h02);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    t_first;
    t_b2b;
    t_halt;
    t_flags;
    stop_test;
  end
endmodule
bind mmir_unit mmir_unit_monitor i_mmir_unit_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .system_mgmt_mode_o(system_mgmt_mode_o), .mgmt_ack_o(mgmt_ack_o),
  .clear_flags_o(clear_flags_o), .ie_flag_o(ie_flag_o), .tf_flag_o(tf_flag_o),
  .debug_en_o(debug_en_o), .cap_save_we_o(cap_save_we_o), .nmi_take_o(nmi_take_o),
  .soft_int_take_o(soft_int_take_o), .maskable_int_request_take_o(maskable_int_request_take_o),
  .halt_reenter_o(halt_reenter_o), .halt_fetch_o(halt_fetch_o), .halt_cycle_o(halt_cycle_o),
  .io_reexec_o(io_reexec_o), .resume_next_o(resume_next_o), .cap_save_o(cap_save_o),
  .vector_addr_o(vector_addr_o));
